//--- shared/ott_regs.svh
// Register map, field positions, reset values and timing of the trip timer
`ifndef OTT_REGS_SVH
`define OTT_REGS_SVH
`define OTT_ADDR_CTRL        8'h00
`define OTT_ADDR_NOMINAL     8'h04
`define OTT_ADDR_STATUS      8'h08
`define OTT_ADDR_MASK        8'h0C
`define OTT_ADDR_STATE       8'h10
`define OTT_ADDR_ACC         8'h14
`define OTT_ADDR_DELAY       8'h18
`define OTT_SREG_PICKUP      3'h0
`define OTT_SREG_TMULT       3'h1
`define OTT_SREG_FIXED       3'h2
`define OTT_SREG_RESET       3'h3
`define OTT_SREG_FLOOR       3'h4
`define OTT_SREG_MODE        3'h5
`define OTT_CTRL_EN_BIT      2
`define OTT_MODE_RMODE_LSB   4
`define OTT_MODE_METHOD_LSB  6
`define OTT_ST_PICK_BIT      0
`define OTT_ST_TRIP_BIT      1
`define OTT_ST_CLR_BIT       2
`define OTT_CTRL_EN_RST      1'b1
`define OTT_NOMINAL_RST      16'h0100
`define OTT_PICKUP_RST       16'h0180
`define OTT_TMULT_RST        16'h0100
`define OTT_FIXED_RST        24'h0003E8
`define OTT_RESET_RST        24'h0003E8
`define OTT_CLK_PERIOD_NS    50
`define OTT_TICK_NS          100000
`define OTT_CEIL_PICK_MULT   20
`define OTT_CEIL_NOM_MULT    40
`define OTT_Q16_ONE          34'h000010000
`define OTT_LN_SCALE         16'h038D
`define OTT_R_INVERSE_CURVE_B           16'h56C9
`define OTT_R_INVERSE_CURVE_C           17'h03C6A
`endif

//--- shared/ott_pkg.sv
// Types shared by the overcurrent trip timer
package ott_pkg;
   typedef enum logic [3:0] {
      fixed_delay_curve      = 4'h0,
      normal_inverse_curve   = 4'h1,
      very_inverse_curve     = 4'h2,
      long_inverse_curve     = 4'h3,
      extreme_inverse_curve  = 4'h4,
      moderate_inverse_curve = 4'h5,
      ieee_very_inverse_curve    = 4'h6,
      ieee_extreme_inverse_curve = 4'h7,
      r_inverse_curve        = 4'h8,
      thermal_flat_curve     = 4'h9,
      thermal_linear_curve   = 4'hA,
      thermal_square_curve   = 4'hB,
      thermal_fourth_curve   = 4'hC
   } ott_curve_e;
   typedef enum logic [1:0] {
      rst_instant = 2'h0, rst_definite = 2'h1, rst_inverse = 2'h2
   } ott_rmode_e;
   typedef enum logic [1:0] {
      fundamental_method = 2'h0, true_rms_method = 2'h1,
      negative_sequence_method = 2'h2
   } ott_method_e;
   typedef enum logic [1:0] {
      st_idle = 2'b00, st_ratio = 2'b01, st_curve = 2'b11, st_scale = 2'b10
   } ott_fsm_e;
   typedef enum logic [2:0] {
      cls_log, cls_lin, cls_sq, cls_r_inverse_curve, cls_pow0, cls_pow1, cls_pow2,
      cls_pow4
   } ott_cls_e;
   typedef struct packed {
      logic [23:0] num;   // Trip numerator, 0.1 ms
      logic [15:0] add;   // Trip offset, 0.1 ms
      logic [23:0] tau;   // Reset numerator, 0.1 ms
      ott_cls_e    cls;
   } ott_curve_t;
   typedef struct packed {
      ott_method_e method;
      ott_rmode_e  rmode;
      ott_curve_e  curve;
      logic [15:0] pickup;                 // Raw current units
      logic [15:0] curve_time_multiplier;  // Q8.8
      logic [23:0] fixed_delay;            // 0.1 ms
      logic [23:0] reset_delay_setting;    // 0.1 ms
      logic [23:0] user_floor_delay;       // 0.1 ms, zero disables
   } ott_set_t;
   typedef struct packed {
      logic [15:0] fund;
      logic [15:0] rms;
      logic [15:0] neg;
   } ott_meas_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } ott_bus_t;
   typedef struct packed {
      ott_set_t [3:0] sets;
      logic [1:0]  act_set;
      logic        en;
      logic [15:0] nominal;
      logic [2:0]  status;
      logic [2:0]  mask;
      logic [31:0] rdata;
      ott_fsm_e    fsm;
      logic [47:0] quo;
      logic [31:0] rem;
      logic [31:0] div;
      logic [5:0]  cnt;
      logic        run_pick;
      logic [23:0] delay;
      logic [23:0] rdly;
      logic [15:0] tick;
      logic [23:0] acc;
      logic [23:0] facc;
      logic [23:0] racc;
      logic        picked;
      logic        trip;
   } ott_state_t;
endpackage

//--- design/ott_core.sv
// Phase overcurrent trip timing element with register port and interrupt
// Operation
// - Non-directional mode ignores fault direction entirely
// - Per-element method selects fundamental or RMS
// - Negative-sequence method compares negative-sequence current
// - Curve field offers fixed, IEC, IEEE, R, thermal
// - Current above pickup starts trip timing
// - Fixed curve trips after fixed delay
// - Inverse delay from multiplier, curve, current multiple
// - Instantaneous reset clears timing within two cycles
// - Definite reset clears after reset delay below pickup
// - Inverse reset delay from curve, not fixed
// - Inverse curves never trip before both floors
// - User floor timer runs independently; zero disables
// - Ceiling is min of twenty pickups, forty nominals
// - Curve delay at ceiling is floor delay
// - All element instances share one structure
// - Settings from active of four sets, adaptive override
// - Fixed curve always resets instantly
`include "ott_regs.svh"
module ott_core #(
   parameter int TICK_NS = `OTT_TICK_NS  // Timer resolution
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire ott_pkg::ott_bus_t  bus,
   output logic [31:0]           rdata,
   input  wire ott_pkg::ott_meas_t meas,
   input  wire logic [5:0]       aps_sel,
   input  wire ott_pkg::ott_set_t  aps_val,
   output logic                  pickup,
   output logic                  trip,
   output logic                  irq
);
   import ott_pkg::*;

   // Timer tick period in clock cycles
   localparam int TICK_CYCLES = TICK_NS / `OTT_CLK_PERIOD_NS;
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

   ott_state_t  q;          // All state
   ott_state_t  d;          // Next state
   ott_set_t    stored;     // Active stored set
   ott_set_t    act;        // Set after adaptive override
   ott_curve_t  lut;        // Constants of the active curve
   logic [15:0] isel;       // Compared current
   logic [21:0] ceil_cur;   // current_ceiling
   logic [15:0] iclamp;     // Current limited to the ceiling
   logic        is_fixed;   // Fixed delay curve active
   logic        is_therm;   // Thermal curve active
   logic        is_inv;     // Inverse curve with floors
   logic        picked_now; // Current above pickup this cycle

   // Curve constants, 0.1 ms units, multiplier applied later
   function automatic ott_curve_t curve_lut(input ott_curve_e c);
      case (c)
         normal_inverse_curve:
            curve_lut = '{24'h000578, 16'h0000, 24'h000578, cls_log};
         very_inverse_curve:
            curve_lut = '{24'h020F58, 16'h0000, 24'h020F58, cls_lin};
         long_inverse_curve:
            curve_lut = '{24'h124F80, 16'h0000, 24'h124F80, cls_lin};
         extreme_inverse_curve:
            curve_lut = '{24'h0C3500, 16'h0000, 24'h0C3500, cls_sq};
         moderate_inverse_curve:
            curve_lut = '{24'h000203, 16'h0474, 24'h00BD74, cls_log};
         ieee_very_inverse_curve:
            curve_lut = '{24'h02FE04, 16'h132E, 24'h034BC0, cls_sq};
         ieee_extreme_inverse_curve:
            curve_lut = '{24'h044D90, 16'h04C1, 24'h0470B8, cls_sq};
         r_inverse_curve:
            curve_lut = '{24'h002710, 16'h0000, 24'h002710, cls_r_inverse_curve};
         thermal_flat_curve:
            curve_lut = '{24'h00C350, 16'h0000, 24'h06DDD0, cls_pow0};
         thermal_linear_curve:
            curve_lut = '{24'h00C350, 16'h0000, 24'h06DDD0, cls_pow1};
         thermal_square_curve:
            curve_lut = '{24'h00C350, 16'h0000, 24'h06DDD0, cls_pow2};
         thermal_fourth_curve:
            curve_lut = '{24'h00C350, 16'h0000, 24'h06DDD0, cls_pow4};
         default:
            curve_lut = '{24'h000000, 16'h0000, 24'h000000, cls_lin};
      endcase
   endfunction

   // Base-2 logarithm of a Q8.8 value in Q16, linear mantissa
   function automatic logic [31:0] log2_q16(input logic [15:0] m);
      int          msb;
      logic [15:0] sh;
      msb = 8;
      for (int i = 8; i < 16; i++) begin
         if (m[i]) begin
            msb = i;
         end
      end
      sh = m << (15 - msb);
      log2_q16 = {16'(msb - 8), sh[14:0], 1'b0};
   endfunction

   // Saturating increment of a timer
   function automatic logic [23:0] sat_inc(input logic [23:0] v);
      sat_inc = (&v) ? v : v + 24'h000001;
   endfunction

   // Settings of the active set, fields replaceable one at a time except curve, rmode and method, which share aps_sel[5]
   assign stored = q.sets[q.act_set];
   assign act.pickup = aps_sel[0] ? aps_val.pickup : stored.pickup;
   assign act.curve_time_multiplier = aps_sel[1] ?
      aps_val.curve_time_multiplier : stored.curve_time_multiplier;
   assign act.fixed_delay = aps_sel[2] ? aps_val.fixed_delay :
      stored.fixed_delay;
   assign act.reset_delay_setting = aps_sel[3] ?
      aps_val.reset_delay_setting : stored.reset_delay_setting;
   assign act.user_floor_delay = aps_sel[4] ? aps_val.user_floor_delay :
      stored.user_floor_delay;
   assign act.curve  = aps_sel[5] ? aps_val.curve  : stored.curve;
   assign act.rmode  = aps_sel[5] ? aps_val.rmode  : stored.rmode;
   assign act.method = aps_sel[5] ? aps_val.method : stored.method;

   // Magnitude only; no direction input exists for this element
   always_comb begin
      case (act.method)
         true_rms_method:          isel = meas.rms;
         negative_sequence_method: isel = meas.neg;
         default:                  isel = meas.fund;
      endcase
   end

   assign lut      = curve_lut(act.curve);
   assign is_fixed = (act.curve == fixed_delay_curve);
   assign is_therm = (act.curve >= thermal_flat_curve);
   assign is_inv   = !is_fixed && !is_therm;
   assign picked_now = q.en && (isel > act.pickup);

   // Ceiling keeps the inverse delay from falling below its floor
   always_comb begin
      logic [21:0] a;
      logic [21:0] b;
      a = 22'(act.pickup) * 22'(`OTT_CEIL_PICK_MULT);
      b = 22'(q.nominal) * 22'(`OTT_CEIL_NOM_MULT);
      ceil_cur = (a < b) ? a : b;
      if (is_inv && (22'(isel) > ceil_cur)) begin
         iclamp = ceil_cur[15:0];
      end else begin
         iclamp = isel;
      end
   end

   // Next-state logic: bus, delay engine, timers, events
   always_comb begin
      logic [32:0] rsh;
      logic [47:0] qsh;
      logic [15:0] m;
      logic [31:0] m2;
      logic signed [65:0] den;
      logic [47:0] num;
      logic [48:0] tsum;
      logic [64:0] prod;
      logic [23:0] res;
      logic [23:0] acc_i;
      logic [23:0] facc_i;
      logic [23:0] racc_i;
      logic [23:0] rlim;
      logic        tick;
      logic        floor_ok;
      logic [2:0]  ev;
      logic [1:0]  sidx;
      logic [2:0]  ridx;
      rsh = '0;
      qsh = '0;
      m = '0;
      m2 = '0;
      den = '0;
      num = '0;
      tsum = '0;
      prod = '0;
      res = '0;
      ev = '0;
      d = q;
      sidx = bus.addr[6:5];
      ridx = bus.addr[4:2];

      // Read data stands one cycle after the strobe
      d.rdata = '0;
      if (bus.rd) begin
         if (bus.addr == `OTT_ADDR_CTRL) begin
            d.rdata = {29'h0, q.en, q.act_set};
         end else if (bus.addr == `OTT_ADDR_NOMINAL) begin
            d.rdata = {16'h0, q.nominal};
         end else if (bus.addr == `OTT_ADDR_STATUS) begin
            d.rdata = {29'h0, q.status};
            d.status = '0;  // Read clears; new events below still set
         end else if (bus.addr == `OTT_ADDR_MASK) begin
            d.rdata = {29'h0, q.mask};
         end else if (bus.addr == `OTT_ADDR_STATE) begin
            d.rdata = {27'h0, q.run_pick, q.fsm, q.trip, q.picked};
         end else if (bus.addr == `OTT_ADDR_ACC) begin
            d.rdata = {8'h0, q.acc};
         end else if (bus.addr == `OTT_ADDR_DELAY) begin
            d.rdata = {8'h0, q.delay};
         end else if (bus.addr[7]) begin
            if (ridx == `OTT_SREG_PICKUP) begin
               d.rdata = {16'h0, q.sets[sidx].pickup};
            end else if (ridx == `OTT_SREG_TMULT) begin
               d.rdata = {16'h0, q.sets[sidx].curve_time_multiplier};
            end else if (ridx == `OTT_SREG_FIXED) begin
               d.rdata = {8'h0, q.sets[sidx].fixed_delay};
            end else if (ridx == `OTT_SREG_RESET) begin
               d.rdata = {8'h0, q.sets[sidx].reset_delay_setting};
            end else if (ridx == `OTT_SREG_FLOOR) begin
               d.rdata = {8'h0, q.sets[sidx].user_floor_delay};
            end else if (ridx == `OTT_SREG_MODE) begin
               d.rdata = {24'h0, q.sets[sidx].method,
                          q.sets[sidx].rmode, q.sets[sidx].curve};
            end
         end
      end

      // Register writes; unmapped addresses are ignored
      if (bus.wr) begin
         if (bus.addr == `OTT_ADDR_CTRL) begin
            d.act_set = bus.wdata[1:0];
            d.en      = bus.wdata[`OTT_CTRL_EN_BIT];
         end else if (bus.addr == `OTT_ADDR_NOMINAL) begin
            d.nominal = bus.wdata[15:0];
         end else if (bus.addr == `OTT_ADDR_MASK) begin
            d.mask = bus.wdata[2:0];
         end else if (bus.addr[7]) begin
            if (ridx == `OTT_SREG_PICKUP) begin
               d.sets[sidx].pickup = bus.wdata[15:0];
            end else if (ridx == `OTT_SREG_TMULT) begin
               d.sets[sidx].curve_time_multiplier = bus.wdata[15:0];
            end else if (ridx == `OTT_SREG_FIXED) begin
               d.sets[sidx].fixed_delay = bus.wdata[23:0];
            end else if (ridx == `OTT_SREG_RESET) begin
               d.sets[sidx].reset_delay_setting = bus.wdata[23:0];
            end else if (ridx == `OTT_SREG_FLOOR) begin
               d.sets[sidx].user_floor_delay = bus.wdata[23:0];
            end else if (ridx == `OTT_SREG_MODE) begin
               // Unknown curve codes fall back to the fixed curve
               d.sets[sidx].curve = (bus.wdata[3:0] > 4'hC) ?
                  fixed_delay_curve : ott_curve_e'(bus.wdata[3:0]);
               d.sets[sidx].rmode = ott_rmode_e'(
                  bus.wdata[`OTT_MODE_RMODE_LSB +: 2]);
               d.sets[sidx].method = ott_method_e'(
                  bus.wdata[`OTT_MODE_METHOD_LSB +: 2]);
            end
         end
      end

      // One restoring division step, shared by both passes
      rsh = {q.rem, q.quo[47]};
      qsh = {q.quo[46:0], 1'b0};
      if (rsh >= {1'b0, q.div}) begin
         rsh = rsh - {1'b0, q.div};
         qsh[0] = 1'b1;
      end

      // Delay engine runs continuously on fresh samples
      case (q.fsm)
         st_idle: begin
            d.run_pick = picked_now;
            d.quo = {24'h0, iclamp, 8'h00};
            d.rem = '0;
            d.div = {16'h0, is_therm ? q.nominal : act.pickup};
            if (d.div == '0) begin
               d.div = 32'h0000_0001;  // Guards a zero setting
            end
            d.cnt = 6'h2F;
            d.fsm = st_ratio;
         end
         st_ratio: begin
            d.rem = rsh[31:0];
            d.quo = qsh;
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
               // Multiple of pickup (or nominal) in Q8.8
               m = (|qsh[47:16]) ? 16'hFFFF : qsh[15:0];
               m2 = 32'(m) * 32'(m);
               if (q.run_pick) begin
                  num = {8'h00, lut.num, 16'h0000};
                  case (lut.cls)
                     cls_log:  den = 66'((log2_q16(m) *
                                  64'(`OTT_LN_SCALE)) >> 16);
                     cls_lin:  den = 66'({m, 8'h00}) - 66'(`OTT_Q16_ONE);
                     cls_sq:   den = 66'(m2) - 66'(`OTT_Q16_ONE);
                     cls_r_inverse_curve: begin
                        den = 66'((32'(m) * 32'(`OTT_R_INVERSE_CURVE_B)) >> 8) -
                              66'(`OTT_R_INVERSE_CURVE_C);
                        num = 48'(lut.num * 40'(m) * 40'h100);
                     end
                     cls_pow0: den = 66'(`OTT_Q16_ONE);
                     cls_pow1: den = 66'({m, 8'h00});
                     cls_pow2: den = 66'(m2);
                     default:  den = 66'((64'(m2) * 64'(m2)) >> 16);
                  endcase
               end else begin
                  num = {8'h00, lut.tau, 16'h0000};
                  if (is_therm) begin
                     den = 66'(`OTT_Q16_ONE);
                  end else begin
                     den = 66'(`OTT_Q16_ONE) - 66'(m2);
                  end
               end
               if (den < 66'sd1) begin
                  den = 66'sd1;
               end else if (den > 66'sh0FFFFFFFF) begin
                  den = 66'sh0FFFFFFFF;
               end
               d.quo = num;
               d.rem = '0;
               d.div = den[31:0];
               d.cnt = 6'h2F;
               d.fsm = st_curve;
            end
         end
         st_curve: begin
            d.rem = rsh[31:0];
            d.quo = qsh;
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
               d.fsm = st_scale;
            end
         end
         st_scale: begin
            tsum = {1'b0, q.quo};
            if (q.run_pick) begin
               tsum = tsum + 49'(lut.add);
            end
            prod = (65'(tsum) * 65'(act.curve_time_multiplier)) >> 8;
            res = (|prod[64:24]) ? 24'hFFFFFF : prod[23:0];
            // Fixed passes yield zero; keeping it would let a later
            // switch to an inverse curve trip at its first tick
            if (q.run_pick && !is_fixed) begin
               d.delay = res;
            end else begin
               d.rdly = res;
            end
            d.fsm = st_idle;
         end
         default: d.fsm = st_idle;
      endcase

      // Free-running timer tick
      tick = (q.tick == TICK_LAST);
      d.tick = tick ? 16'h0000 : q.tick + 16'h0001;
      acc_i = sat_inc(q.acc);
      facc_i = sat_inc(q.facc);
      racc_i = sat_inc(q.racc);
      floor_ok = !is_inv || (act.user_floor_delay == '0) ||
                 (facc_i >= act.user_floor_delay);
      rlim = (act.rmode == rst_definite) ?
             act.reset_delay_setting : q.rdly;
      d.picked = picked_now;

      if (picked_now) begin
         d.racc = '0;
         if (tick) begin
            d.acc = acc_i;
            d.facc = facc_i;
            if (is_fixed) begin
               if (acc_i >= act.fixed_delay) begin
                  d.trip = 1'b1;
               end
            end else if ((acc_i >= q.delay) && floor_ok) begin
               d.trip = 1'b1;
            end
         end
      end else begin
         d.facc = '0;
         if (is_fixed || (act.rmode == rst_instant) ||
             (act.rmode != rst_definite && act.rmode != rst_inverse)) begin
            d.acc = '0;
            d.racc = '0;
         end else if (tick) begin
            d.racc = racc_i;
            if (racc_i >= rlim) begin
               d.acc = '0;
               d.racc = '0;
            end
         end
         if (q.acc == '0) begin
            d.trip = 1'b0;
         end
      end

      // Sticky events; a new event wins over a clearing read
      ev[`OTT_ST_PICK_BIT] = picked_now && !q.picked;
      ev[`OTT_ST_TRIP_BIT] = d.trip && !q.trip;
      ev[`OTT_ST_CLR_BIT]  = !picked_now && (q.acc != '0) && (d.acc == '0);
      d.status = d.status | ev;
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.en <= `OTT_CTRL_EN_RST;
         q.nominal <= `OTT_NOMINAL_RST;
         q.delay <= 24'hFFFFFF;  // No early trip before first result
         q.rdly <= 24'hFFFFFF;
         q.div <= 32'h0000_0001;
         for (int i = 0; i < 4; i++) begin
            q.sets[i].pickup <= `OTT_PICKUP_RST;
            q.sets[i].curve_time_multiplier <= `OTT_TMULT_RST;
            q.sets[i].fixed_delay <= `OTT_FIXED_RST;
            q.sets[i].reset_delay_setting <= `OTT_RESET_RST;
         end
      end else if (ce) begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign rdata  = q.rdata;
   assign pickup = q.picked;
   assign trip   = q.trip;
   assign irq    = |(q.status & q.mask);
endmodule // ott_core

//--- dv/ott_core_chk.sv
// Port checker for the overcurrent trip timer, bound to ott_core
`include "ott_regs.svh"
module ott_core_chk (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire ott_pkg::ott_bus_t bus,
   input wire logic [31:0]       rdata,
   input wire logic              pickup,
   input wire logic              trip,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import ott_pkg::*;
   logic [2:0] mask_q;  // Shadow of the interrupt mask
   logic       inst_q;  // Set 0 clears its timing at once
   // Shadow mask and reset style from bus writes; the fixed curve always
   // resets at once, whatever reset mode is written
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= 3'h0;
         inst_q <= 1'b1;
      end else if (bus.wr) begin
         if (bus.addr == `OTT_ADDR_MASK) mask_q <= bus.wdata[2:0];
         if (bus.addr == 8'h94) inst_q <= bus.wdata[3:0] == 4'h0 ||
            !(bus.wdata[5:4] inside {2'h1, 2'h2});
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Control write followed by its read back
   sequence s_ctrl_wr_rd;
      bus.wr && bus.addr == `OTT_ADDR_CTRL ##2
      bus.rd && bus.addr == `OTT_ADDR_CTRL;
   endsequence
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data outside its slot");
   a_ctrl_back: assert property (
      s_ctrl_wr_rd |=> rdata[2:0] == $past(bus.wdata[2:0], 3))
      else $error("control read back differs");
   a_unmapped_zero: assert property (
      bus.rd && bus.addr == 8'h7C |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_mask_quiet: assert property (
      mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
      else $error("irq with empty mask");
   a_trip_cause: assert property (
      $rose(trip) |-> pickup && $past(pickup))
      else $error("trip without pickup");
   a_trip_holds: assert property (trip && pickup |=> trip)
      else $error("trip dropped above pickup");
   a_trip_drop: assert property ($fell(trip) |-> !pickup)
      else $error("trip fell while picked up");
   a_inst_reset: assert property (
      inst_q && $fell(pickup) |-> ##[1:2] !trip)
      else $error("instant reset too slow");
endmodule // ott_core_chk
bind ott_core ott_core_chk u_chk (.clk(clk), .rst_n(rst_n), .bus(bus),
   .rdata(rdata), .pickup(pickup), .trip(trip), .irq(irq));

//--- dv/ott_meas_model.sv
// Measurement front end model feeding currents to the trip timer
module ott_meas_model (
   input  wire logic          clk,
   input  wire logic          slow,    // Lagging front end, updates every fourth cycle
   input  wire ott_pkg::ott_meas_t target,  // Currents asked for
   output ott_pkg::ott_meas_t meas
);
   timeunit 1ns;
   timeprecision 1ns;
   import ott_pkg::*;
   logic [1:0] ph_q = 2'h0;  // Sample phase in slow mode
   // Slow mode updates every fourth cycle, so steps arrive late
   always_ff @(posedge clk) begin
      ph_q <= ph_q + 2'h1;
      if (!slow || ph_q == 2'h0) meas <= target;
   end
endmodule // ott_meas_model

//--- dv/tb_top.sv
// Self-checking bench for the overcurrent trip timer
`include "ott_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ott_pkg::*;
   localparam int T = 20;  // Cycles per timer tick with TICK_NS 1000
   localparam logic [7:0]  RA [9] = '{8'h00, 8'h04, 8'h80, 8'h84, 8'h88,
      8'h8C, 8'h90, 8'h94, 8'hE0};
   localparam logic [31:0] RV [9] = '{32'h4, 32'h100, 32'h180, 32'h100,
      32'h3E8, 32'h3E8, 32'h0, 32'h0, 32'h180};
   logic        clk, rst_n, slow, pickup, trip, irq;
   logic [31:0] rdata;
   ott_bus_t    bus;
   ott_meas_t   tgt, meas;
   logic [5:0]  aps_s;  // Adaptive override select
   ott_set_t    aps_v;  // Adaptive override values
   int          err_total, n_checks;
   // Short tick keeps long delays inside the run
   ott_core #(.TICK_NS(1000)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .bus(bus), .rdata(rdata), .meas(meas), .aps_sel(aps_s),
      .aps_val(aps_v), .pickup(pickup), .trip(trip), .irq(irq));
   ott_meas_model u_fe (.clk(clk), .slow(slow), .target(tgt), .meas(meas));
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One bus cycle; a read is judged on the masked bits only
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d,
                      logic [31:0] m);
      @(posedge clk);
      bus <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
      #1 if (!w) chk(rdata & m, d & m);
   endtask
   task automatic setc(ott_meas_t v, logic s = 1'b0);
      @(posedge clk);
      tgt <= v;
      slow <= s;
      #1;
   endtask
   // Bounded wait for trip, judged against a window of cycles
   task automatic wait_trip(int lo, int hi);
      int n;
      n = 0;
      while (trip !== 1'b1 && n < hi) begin
         cyc(1);
         n++;
      end
      chk(32'(trip === 1'b1 && n >= lo), 32'h1);
   endtask
   task automatic t_regs();
      acc(1, 8'h7C, 32'h5A, 0);
      acc(0, 8'h7C, 32'h0, '1);
      foreach (RA[i]) acc(0, RA[i], RV[i], '1);
      acc(1, `OTT_ADDR_CTRL, 32'h6, 0);
      acc(0, `OTT_ADDR_CTRL, 32'h6, '1);
      acc(1, `OTT_ADDR_CTRL, 32'h4, 0);
      $display("registers done");
   endtask
   // Fixed curve per method; the other channels are high as decoys
   task automatic t_fixed();
      ott_meas_t m3;
      acc(1, `OTT_ADDR_MASK, 32'h7, 0);
      acc(1, 8'h88, 32'h3, 0);
      for (int m = 0; m < 3; m++) begin
         acc(1, 8'h94, 32'((m << 6) | ((m % 2 + 1) << 4)), 0);
         m3 = {3{16'h0200}};
         m3[32 - 16 * m +: 16] = 16'h0100;
         setc(m3);
         cyc(6);
         chk(pickup, 0);
         setc({3{16'h0200}});
         wait_trip(2 * T, 3 * T + 3);
         chk(irq, 1);
         acc(0, `OTT_ADDR_STATUS, 32'h3, 32'h3);
         cyc(2);
         chk(irq, 0);
         setc('0);
         cyc(4);
         chk(trip, 0);
         acc(0, `OTT_ADDR_STATUS, 32'h4, 32'h4);
      end
      acc(1, `OTT_ADDR_MASK, 32'h0, 0);
      $display("fixed curve done");
   endtask
   // Very inverse curve: user floor first, then the ceiling floor
   task automatic t_floor();
      acc(1, 8'h84, 32'h1, 0);
      acc(1, 8'h90, 32'h3C, 0);
      acc(1, 8'h94, 32'h2, 0);
      setc('{16'hFFFF, 16'h0, 16'h0});
      wait_trip(59 * T, 62 * T);
      setc('0);
      acc(1, 8'h90, 32'h0, 0);
      cyc(3);
      setc('{16'hFFFF, 16'h0, 16'h0});
      wait_trip(25 * T, 32 * T);
      setc('0);
      cyc(4);
      $display("floors done");
   endtask
   // Thermal flat curve with delayed reset through a lagging front end
   task automatic t_definite();
      acc(1, 8'h8C, 32'h5, 0);
      acc(1, 8'h94, 32'h19, 0);
      setc('{16'h0200, 16'h0, 16'h0});
      wait_trip(190 * T, 200 * T);
      setc('0, 1'b1);
      cyc(4 * T - 2);
      chk(trip, 1);
      cyc(2 * T + 5);
      chk(trip, 0);
      setc('0);
      $display("definite reset done");
   endtask
   // Pickup from an adaptive override, then from set 1 made active
   task automatic t_adapt();
      acc(1, 8'hA0, 32'h300, 0);
      @(posedge clk);
      aps_s <= 6'h01;
      aps_v.pickup <= 16'h0300;
      tgt <= '{16'h0200, 16'h0, 16'h0};
      cyc(5);
      chk(pickup, 0);
      @(posedge clk);
      aps_s <= 6'h00;
      cyc(4);
      chk(pickup, 1);
      acc(1, `OTT_ADDR_CTRL, 32'h5, 0);
      cyc(3);
      chk(pickup, 0);
      $display("adaptive sets done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog well beyond the roughly 6000 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      slow = 1'b0;
      bus = '0;
      tgt = '0;
      aps_s = '0;
      aps_v = '0;
      err_total = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_regs();
      t_fixed();
      t_floor();
      t_definite();
      t_adapt();
      complete_run();
   end
endmodule // tb_top
